// ---- src/sacp_pkg.sv ----
// Constants, field layout and types for the shunt converter pair config block.
// Assumes an Avalon-MM master with 32-bit data and byte addressing.
// Contract
// - Bit 11 picks continuous or single-shot
// - Bits 10:8 pick shared oversampling ratio
// - Bit 3 enables global chop
// - Bits 2:0 pick chop delay periods
// - Reserved configuration bits always read zero
// - Current converter enable resets to one
// - Result cleared when disabled or asleep
// - Counter cleared when both converters off
// - Gain codes 4, 8, 16, 32
// - Bits 9:8 pick current converter input
// - Bit 5 steers test source pin
// - Bit 4 steers test sink pin
// - Test current magnitudes off, 4, 40, 240
// - Register 84h holds trim bits 23:8
// - Trim is signed, low byte from 85h
package sacp_pkg;

	// Bus geometry: byte address, index is address / 4
	localparam int unsigned AV_ADDR_W = 10;
	localparam int unsigned IDX_LSB   = 2;
	localparam int unsigned IDX_MSB   = 9;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SHARED_CFG  = 8'h82;
	localparam logic [7:0] IDX_CURRENT_CFG = 8'h83;
	localparam logic [7:0] IDX_TRIM_UPPER  = 8'h84;
	localparam logic [7:0] IDX_TRIM_LOWER  = 8'h85;
	localparam logic [7:0] IDX_RESULT      = 8'h90;

	// Reset values
	localparam logic [15:0] RST_SHARED_CFG  = 16'h0400;
	localparam logic [15:0] RST_CURRENT_CFG = 16'h8010;
	localparam logic [15:0] RST_TRIM_UPPER  = 16'h0000;
	localparam logic [7:0]  RST_TRIM_LOWER  = 8'h00;

	// Writable bits; everything else is reserved and reads zero
	localparam logic [15:0] WMASK_SHARED    = 16'h0f0f;
	localparam logic [15:0] WMASK_CURRENT   = 16'h8f3f;
	localparam logic [15:0] WMASK_TRIM_UP   = 16'hffff;
	localparam logic [15:0] WMASK_TRIM_LOW  = 16'hff00;

	// Shared configuration fields
	localparam int unsigned SH_MODE_BIT  = 11;
	localparam int unsigned SH_OSR_MSB   = 10;
	localparam int unsigned SH_OSR_LSB   = 8;
	localparam int unsigned SH_CHOP_BIT  = 3;
	localparam int unsigned SH_DLY_MSB   = 2;
	localparam int unsigned SH_DLY_LSB   = 0;

	// Current channel configuration fields
	localparam int unsigned CC_EN_BIT    = 15;
	localparam int unsigned CC_GAIN_MSB  = 11;
	localparam int unsigned CC_GAIN_LSB  = 10;
	localparam int unsigned CC_MUX_MSB   = 9;
	localparam int unsigned CC_MUX_LSB   = 8;
	localparam int unsigned CC_SRC_PIN   = 5;
	localparam int unsigned CC_SNK_PIN   = 4;
	localparam int unsigned CC_SRC_MSB   = 3;
	localparam int unsigned CC_SRC_LSB   = 2;
	localparam int unsigned CC_SNK_MSB   = 1;
	localparam int unsigned CC_SNK_LSB   = 0;

	// Lower trim register: trim bits 7:0 sit in register bits 15:8
	localparam int unsigned TL_MSB       = 15;
	localparam int unsigned TL_LSB       = 8;

	// Result register layout
	localparam int unsigned RS_CNT_LSB   = 24;

	// Decode tables
	localparam logic [13:0] OSR_BASE     = 14'h0040;
	localparam logic [8:0]  CHOP_BASE    = 9'h002;
	localparam logic [7:0]  MAG_OFF      = 8'h00;
	localparam logic [7:0]  MAG_4UA      = 8'h04;
	localparam logic [7:0]  MAG_40UA     = 8'h28;
	localparam logic [7:0]  MAG_240UA    = 8'hf0;
	localparam logic [3:0]  PATH_DIRECT  = 4'h1;

	// Avalon response codes
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;

	// Bus handshake states, Gray ordered
	typedef enum logic {
		SACP_BUS_IDLE   = 1'b0,
		SACP_BUS_ANSWER = 1'b1
	} sacp_bus_state_t;

endpackage : sacp_pkg

// ---- src/sacp_cfg_decode.sv ----
// Table decode from configuration codes to converter-facing values.
// Pure combinational; the caller registers every result.
`timescale 1ns/1ps
module sacp_cfg_decode
	import sacp_pkg::*;
(
	input  wire logic [2:0]  i_osr_code,     // Oversampling code
	input  wire logic [2:0]  i_delay_code,   // Chop delay code
	input  wire logic [1:0]  i_gain_code,    // Gain code
	input  wire logic [1:0]  i_mux_code,     // Input select code
	input  wire logic [1:0]  i_src_code,     // Source magnitude code
	input  wire logic [1:0]  i_snk_code,     // Sink magnitude code
	output logic      [13:0] o_osr_ratio,    // 64 .. 8192
	output logic      [8:0]  o_chop_periods, // 2 .. 256
	output logic             o_analog_x8,    // Analog gain 8 instead of 4
	output logic      [1:0]  o_digital_shift,// Extra digital doubling steps
	output logic      [3:0]  o_path,         // One-hot input path
	output logic      [7:0]  o_src_ua,       // Source current in uA
	output logic      [7:0]  o_snk_ua        // Sink current in uA
);

	// Current magnitude table, shared by source and sink
	function automatic logic [7:0] sacp_mag(input logic [1:0] code);
		unique case (code)
			2'b00: sacp_mag = MAG_OFF;
			2'b01: sacp_mag = MAG_4UA;
			2'b10: sacp_mag = MAG_40UA;
			2'b11: sacp_mag = MAG_240UA;
		endcase
	endfunction : sacp_mag

	// Ratios and delays are powers of two, so a shift is the whole table
	always_comb begin
		o_osr_ratio    = OSR_BASE << i_osr_code;
		o_chop_periods = CHOP_BASE << i_delay_code;
		o_analog_x8     = (i_gain_code != 2'b00);
		o_digital_shift = (i_gain_code[1]) ? {1'b0, i_gain_code[0]} + 2'b01
			: 2'b00;
		o_path = PATH_DIRECT << i_mux_code;
		o_src_ua = sacp_mag(i_src_code);
		o_snk_ua = sacp_mag(i_snk_code);
	end

endmodule : sacp_cfg_decode

// ---- src/sacp_top.sv ----
// Register file and applied settings for the shunt converter pair.
// Assumes an Avalon-MM master holding each request until waitrequest is
// low; converter pulses are synchronous to i_core_clk.
`timescale 1ns/1ps
module sacp_top
	import sacp_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	// Avalon-MM slave
	input  wire logic [AV_ADDR_W-1:0] i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic      [31:0]          o_avs_readdata,
	output logic                      o_avs_waitrequest,
	output logic      [1:0]           o_avs_response,
	// Converter side
	input  wire logic                 i_conversion_start,
	input  wire logic [23:0]          i_current_data,
	input  wire logic                 i_current_data_valid,
	input  wire logic                 i_voltage_converter_enable,
	input  wire logic                 i_standby,
	input  wire logic                 i_power_down,
	output logic                      o_current_converter_enable,
	output logic                      o_pair_conversion_mode,
	output logic      [13:0]          o_pair_oversampling_ratio,
	output logic                      o_pair_chop_enable,
	output logic      [8:0]           o_pair_chop_delay,
	output logic                      o_current_analog_gain_x8,
	output logic      [1:0]           o_current_digital_gain_shift,
	output logic      [3:0]           o_current_input_select,
	output logic                      o_test_source_pin_select,
	output logic                      o_test_sink_pin_select,
	output logic      [7:0]           o_test_source_magnitude,
	output logic      [7:0]           o_test_sink_magnitude,
	output logic      [23:0]          o_current_offset_trim,
	output logic      [23:0]          o_current_result,
	output logic      [1:0]           o_pair_conversion_counter
);

	// Whole state of the block in one record
	typedef struct packed {
		sacp_bus_state_t bus;          // Handshake phase
		logic            waitreq;      // Registered waitrequest
		logic [31:0]     rdata;        // Registered read data
		logic [1:0]      resp;         // Registered response
		logic [15:0]     shared;       // Shared configuration as written
		logic [15:0]     current;      // Current channel configuration
		logic [15:0]     trim_hi;      // Trim bits 23:8
		logic [7:0]      trim_lo;      // Trim bits 7:0
		logic [15:0]     app_shared;   // Shared settings in use
		logic [15:0]     app_current;  // Channel settings in use
		logic [23:0]     app_trim;     // Trim in use
		logic [23:0]     result;       // Latest current conversion
		logic [1:0]      counter;      // Pair conversion counter
		logic [13:0]     osr_ratio;    // Decoded ratio
		logic [8:0]      chop_periods; // Decoded chop delay
		logic            analog_x8;    // Decoded analog gain
		logic [1:0]      dig_shift;    // Decoded digital gain
		logic [3:0]      path;         // Decoded input path
		logic [7:0]      src_ua;       // Decoded source current
		logic [7:0]      snk_ua;       // Decoded sink current
	} sacp_state_t;

	// Reset image; decoded fields match the reset settings
	localparam sacp_state_t RESET_STATE = '{
		bus: SACP_BUS_IDLE, waitreq: 1'b1, rdata: '0, resp: RESP_OK,
		shared: RST_SHARED_CFG, current: RST_CURRENT_CFG,
		trim_hi: RST_TRIM_UPPER, trim_lo: RST_TRIM_LOWER,
		app_shared: RST_SHARED_CFG, app_current: RST_CURRENT_CFG,
		app_trim: '0, result: '0, counter: '0,
		osr_ratio: OSR_BASE << RST_SHARED_CFG[SH_OSR_MSB:SH_OSR_LSB],
		chop_periods: CHOP_BASE, analog_x8: 1'b0, dig_shift: 2'b00,
		path: PATH_DIRECT, src_ua: MAG_OFF, snk_ua: MAG_OFF};

	sacp_state_t state;        // Registered state
	sacp_state_t next_state;   // Next state
	logic [7:0]  idx;          // Register index from byte address
	logic        req;          // Any bus request
	logic        mapped;       // Index hits a register
	logic [31:0] rd_mux;       // Read value for the addressed register
	logic [15:0] lane_mask;    // Byte enables as a bit mask
	logic [15:0] next_app_shared;  // Shared settings in use next cycle
	logic [15:0] next_app_current; // Channel settings in use next cycle
	logic [13:0] dec_osr;      // Decoder results for the next settings
	logic [8:0]  dec_chop;
	logic        dec_x8;
	logic [1:0]  dec_shift;
	logic [3:0]  dec_path;
	logic [7:0]  dec_src;
	logic [7:0]  dec_snk;

	assign idx       = i_avs_address[IDX_MSB:IDX_LSB];
	assign req       = i_avs_read | i_avs_write;
	assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

	// Merge a write under byte lanes and the writable mask
	function automatic logic [15:0] sacp_merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [15:0] m);
		sacp_merge = (old & ~m) | (wd & m);
	endfunction : sacp_merge

	// Read decode; reserved bits are zero because the read masks them off
	always_comb begin
		rd_mux = '0;
		mapped = 1'b1;
		unique case (idx)
			IDX_SHARED_CFG:  rd_mux[15:0] = state.shared & WMASK_SHARED;
			IDX_CURRENT_CFG: rd_mux[15:0] = state.current & WMASK_CURRENT;
			IDX_TRIM_UPPER:  rd_mux[15:0] = state.trim_hi;
			IDX_TRIM_LOWER:  rd_mux[TL_MSB:TL_LSB] = state.trim_lo;
			IDX_RESULT:      rd_mux = {6'h00, state.counter, state.result};
			default:         mapped = 1'b0;
		endcase
	end

	// settings move at conversion start
	// Kept outside next_state so the decoder forms no loop through it
	assign next_app_shared  = i_conversion_start ? state.shared
		: state.app_shared;
	assign next_app_current = i_conversion_start ? state.current
		: state.app_current;

	// Decoder sees the settings that will be in use next cycle
	sacp_cfg_decode u_decode (
		.i_osr_code      (next_app_shared[SH_OSR_MSB:SH_OSR_LSB]),
		.i_delay_code    (next_app_shared[SH_DLY_MSB:SH_DLY_LSB]),
		.i_gain_code     (next_app_current[CC_GAIN_MSB:CC_GAIN_LSB]),
		.i_mux_code      (next_app_current[CC_MUX_MSB:CC_MUX_LSB]),
		.i_src_code      (next_app_current[CC_SRC_MSB:CC_SRC_LSB]),
		.i_snk_code      (next_app_current[CC_SNK_MSB:CC_SNK_LSB]),
		.o_osr_ratio     (dec_osr),
		.o_chop_periods  (dec_chop),
		.o_analog_x8     (dec_x8),
		.o_digital_shift (dec_shift),
		.o_path          (dec_path),
		.o_src_ua        (dec_src),
		.o_snk_ua        (dec_snk)
	);

	// Next-state logic: bus handshake, settings transfer, result capture
	always_comb begin
		next_state = state;
		// Bus: one wait cycle, then the answer edge
		unique case (state.bus)
			SACP_BUS_IDLE: begin
				if (req) begin
					next_state.bus     = SACP_BUS_ANSWER;
					next_state.waitreq = 1'b0;
					next_state.rdata   = i_avs_read ? rd_mux : '0;
					next_state.resp    = mapped ? RESP_OK : RESP_DECERR;
				end
			end
			SACP_BUS_ANSWER: begin
				// Master samples waitrequest low here; writes land now
				next_state.bus     = SACP_BUS_IDLE;
				next_state.waitreq = 1'b1;
				next_state.rdata   = '0;
				next_state.resp    = RESP_OK;
				if (i_avs_write) begin
					unique case (idx)
						IDX_SHARED_CFG: next_state.shared = sacp_merge(
							state.shared, i_avs_writedata[15:0],
							lane_mask & WMASK_SHARED);
						IDX_CURRENT_CFG: next_state.current = sacp_merge(
							state.current, i_avs_writedata[15:0],
							lane_mask & WMASK_CURRENT);
						IDX_TRIM_UPPER: next_state.trim_hi = sacp_merge(
							state.trim_hi, i_avs_writedata[15:0],
							lane_mask & WMASK_TRIM_UP);
						IDX_TRIM_LOWER: begin
							if (i_avs_byteenable[1]) begin
								next_state.trim_lo =
									i_avs_writedata[TL_MSB:TL_LSB];
							end
						end
						default: begin
							// Unmapped write: no effect
						end
					endcase
				end
			end
		endcase
		// Applied settings from the same mux that feeds the decoder
		next_state.app_shared  = next_app_shared;
		next_state.app_current = next_app_current;
		if (i_conversion_start) begin
			next_state.app_trim    = {state.trim_hi, state.trim_lo};
		end
		next_state.osr_ratio    = dec_osr;
		next_state.chop_periods = dec_chop;
		next_state.analog_x8    = dec_x8;
		next_state.dig_shift    = dec_shift;
		next_state.path         = dec_path;
		next_state.src_ua       = dec_src;
		next_state.snk_ua       = dec_snk;
		// Conversion results and the shared counter
		if (i_current_data_valid) begin
			next_state.result  = i_current_data;
			next_state.counter = state.counter + 2'b01;
		end
		if (!state.current[CC_EN_BIT] || i_standby || i_power_down) begin
			next_state.result = '0;
		end
		if (!state.current[CC_EN_BIT] && !i_voltage_converter_enable) begin
			next_state.counter = '0;
		end
	end

	// State register; enable set at reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= RESET_STATE;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from state; enable acts at once so a disable clears
	assign o_avs_readdata               = state.rdata;
	assign o_avs_waitrequest            = state.waitreq;
	assign o_avs_response               = state.resp;
	assign o_current_converter_enable   = state.current[CC_EN_BIT];
	assign o_pair_conversion_mode       = state.app_shared[SH_MODE_BIT];
	assign o_pair_oversampling_ratio    = state.osr_ratio;
	assign o_pair_chop_enable           = state.app_shared[SH_CHOP_BIT];
	assign o_pair_chop_delay            = state.chop_periods;
	assign o_current_analog_gain_x8     = state.analog_x8;
	assign o_current_digital_gain_shift = state.dig_shift;
	assign o_current_input_select       = state.path;
	assign o_test_source_pin_select     = state.app_current[CC_SRC_PIN];
	assign o_test_sink_pin_select       = state.app_current[CC_SNK_PIN];
	assign o_test_source_magnitude      = state.src_ua;
	assign o_test_sink_magnitude        = state.snk_ua;
	assign o_current_offset_trim        = state.app_trim;
	assign o_current_result             = state.result;
	assign o_pair_conversion_counter    = state.counter;

	// Checks on the block's own behaviour
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	logic answer_rd;   // Read answered this cycle
	assign answer_rd = !o_avs_waitrequest && i_avs_read;

	a_mode_applied: assert property (
		i_conversion_start |=>
			o_pair_conversion_mode == $past(state.shared[SH_MODE_BIT]))
		else $error("conversion mode not applied at start");

	a_osr_ratio_map: assert property (
		o_pair_oversampling_ratio ==
			(OSR_BASE << state.app_shared[SH_OSR_MSB:SH_OSR_LSB]))
		else $error("oversampling ratio does not match code");

	a_chop_applied: assert property (
		i_conversion_start |=>
			o_pair_chop_enable == $past(state.shared[SH_CHOP_BIT]))
		else $error("chop enable not applied at start");

	a_chop_delay_map: assert property (
		o_pair_chop_delay ==
			(CHOP_BASE << state.app_shared[SH_DLY_MSB:SH_DLY_LSB]))
		else $error("chop delay does not match code");

	a_shared_rsvd_zero: assert property (
		answer_rd && idx == IDX_SHARED_CFG |->
			(o_avs_readdata & ~{16'h0000, WMASK_SHARED}) == '0)
		else $error("shared reserved bits read nonzero");

	a_current_rsvd_zero: assert property (
		answer_rd && idx == IDX_CURRENT_CFG |->
			(o_avs_readdata & ~{16'h0000, WMASK_CURRENT}) == '0)
		else $error("channel reserved bits read nonzero");

	a_enable_after_rst: assert property (
		$past(i_rst) |-> o_current_converter_enable)
		else $error("converter not enabled after reset");

	a_result_cleared: assert property (
		!o_current_converter_enable || i_standby || i_power_down |=>
			o_current_result == '0)
		else $error("result not cleared while idle");

	a_counter_cleared: assert property (
		!o_current_converter_enable && !i_voltage_converter_enable |=>
			o_pair_conversion_counter == '0)
		else $error("counter not cleared with both off");

	a_gain_split: assert property (
		state.app_current[CC_GAIN_MSB] |->
			o_current_analog_gain_x8 && o_current_digital_gain_shift ==
			{1'b0, state.app_current[CC_GAIN_LSB]} + 2'b01)
		else $error("digital gain split wrong");

	a_input_path: assert property (
		o_current_input_select ==
			(PATH_DIRECT << state.app_current[CC_MUX_MSB:CC_MUX_LSB]))
		else $error("input path does not match code");

	a_test_pins: assert property (
		i_conversion_start |=> o_test_source_pin_select ==
			$past(state.current[CC_SRC_PIN]) && o_test_sink_pin_select ==
			$past(state.current[CC_SNK_PIN]))
		else $error("test pin steering not applied");

	a_trim_applied: assert property (
		i_conversion_start |=> o_current_offset_trim ==
			$past({state.trim_hi, state.trim_lo}))
		else $error("offset trim not applied at start");

	a_one_wait: assert property (
		req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
			o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	c_write_done:  cover property (!o_avs_waitrequest && i_avs_write);
	c_conv_start:  cover property (i_conversion_start ##1 i_current_data_valid);
	c_standby_clr: cover property (i_standby ##1 o_current_result == '0);
	c_count_wrap:  cover property (o_pair_conversion_counter == 2'b11
		##1 i_current_data_valid);

endmodule : sacp_top

// ---- dv/sacp_top_bench.sv ----
// Self-checking bench for the shunt converter pair config block.
// Assumes one wait cycle per bus access and pulse-driven converter inputs.
`timescale 1ns/1ps
module sacp_top_bench;
	import sacp_pkg::*;

	// One row: words written with reserved bits set, applied values expected
	typedef struct packed {
		logic [15:0] sh;
		logic [15:0] cc;
		logic [13:0] ratio;
		logic [8:0]  dly;
		logic [3:0]  path;
		logic [7:0]  src;
		logic [7:0]  snk;
		logic        x8;
		logic [1:0]  shift;
	} sacp_row_t;

	sacp_row_t rows [8] = '{
		'{16'hf0f0, 16'hf0c3, 14'h0040, 9'h002, 4'h1, 8'h00, 8'hf0, 1'b0, 2'h0},
		'{16'hf9f1, 16'hf5e6, 14'h0080, 9'h004, 4'h2, 8'h04, 8'h28, 1'b1, 2'h0},
		'{16'hf2fa, 16'hfad9, 14'h0100, 9'h008, 4'h4, 8'h28, 8'h04, 1'b1, 2'h1},
		'{16'hfbfb, 16'hfffc, 14'h0200, 9'h010, 4'h8, 8'hf0, 8'h00, 1'b1, 2'h2},
		'{16'hf4f4, 16'hf0c3, 14'h0400, 9'h020, 4'h1, 8'h00, 8'hf0, 1'b0, 2'h0},
		'{16'hfdf5, 16'hf5e6, 14'h0800, 9'h040, 4'h2, 8'h04, 8'h28, 1'b1, 2'h0},
		'{16'hf6fe, 16'hfad9, 14'h1000, 9'h080, 4'h4, 8'h28, 8'h04, 1'b1, 2'h1},
		'{16'hffff, 16'hfffc, 14'h2000, 9'h100, 4'h8, 8'hf0, 8'h00, 1'b1, 2'h2}};

	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, start = 1'b0;
	logic ven = 1'b1, sby = 1'b0, pdn = 1'b0, wq, en, mode, chop, x8;
	logic sp, kp, dv = 1'b0;
	logic [AV_ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0, rdata, got;
	logic [23:0] cdata = '0, trim, res;
	logic [13:0] ratio, prev;
	logic [8:0]  dly;
	logic [7:0]  src, snk;
	logic [3:0]  path;
	logic [1:0]  rsp, shift, cnt, got_rsp;
	int n_fail = 0, compares = 0, cyc = 0;

	// Free-running 40 MHz core clock
	initial begin
		forever #12.5 clk = ~clk;
	end

	sacp_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wq), .o_avs_response(rsp),
		.i_conversion_start(start), .i_current_data(cdata),
		.i_current_data_valid(dv), .i_voltage_converter_enable(ven),
		.i_standby(sby), .i_power_down(pdn),
		.o_current_converter_enable(en), .o_pair_conversion_mode(mode),
		.o_pair_oversampling_ratio(ratio), .o_pair_chop_enable(chop),
		.o_pair_chop_delay(dly), .o_current_analog_gain_x8(x8),
		.o_current_digital_gain_shift(shift), .o_current_input_select(path),
		.o_test_source_pin_select(sp), .o_test_sink_pin_select(kp),
		.o_test_source_magnitude(src), .o_test_sink_magnitude(snk),
		.o_current_offset_trim(trim), .o_current_result(res),
		.o_pair_conversion_counter(cnt));

	// Verdict and end of run; the only exit point
	task test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// Case-inequality compare so an unknown never matches
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Watchdog: a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			test_done();
		end
	end

	// Avalon access: hold the request until waitrequest is sampled low
	task bus(input logic we, input logic [7:0] idx, input logic [15:0] wd);
		@(posedge clk);
		addr <= {idx, 2'b00};
		rd <= ~we;
		wr <= we;
		wdata <= {16'h0000, wd};
		@(posedge clk);
		while (wq !== 1'b0) @(posedge clk);
		// Answer edge: take data and response, then release
		got = rdata;
		got_rsp = rsp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// Read one register and compare data and response code
	task rchk(input logic [7:0] idx, input logic [31:0] exp,
		input logic [1:0] r);
		bus(1'b0, idx, 16'h0000);
		chk("readdata", got, exp);
		chk("response", {30'h0, got_rsp}, {30'h0, r});
	endtask : rchk

	// Drive a strobe for n edges, then let outputs settle
	task pulse(input bit is_start, input int n);
		@(posedge clk);
		if (is_start) start <= 1'b1;
		else dv <= 1'b1;
		repeat (n) @(posedge clk);
		start <= 1'b0;
		dv <= 1'b0;
		@(negedge clk);
	endtask : pulse

	initial begin
		prev = 14'h0400;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		// Reset values at the pins and in the registers
		chk("ratio", ratio, 14'h0400);
		chk("enable", en, 1'b1);
		chk("sink_pin", kp, 1'b1);
		chk("delay", dly, 9'h002);
		chk("path", path, 4'h1);
		chk("mode", {chop, mode, sp, src, snk}, '0);
		rchk(8'h82, 32'h0000_0400, 2'h0);
		rchk(8'h83, 32'h0000_8010, 2'h0);
		rchk(8'h84, 32'h0000_0000, 2'h0);
		// Table: every code of every field but the enable bit, reserved bits written as ones
		foreach (rows[i]) begin
			bus(1'b1, 8'h82, rows[i].sh);
			bus(1'b1, 8'h83, rows[i].cc);
			rchk(8'h82, {16'h0000, rows[i].sh & 16'h0f0f}, 2'h0);
			rchk(8'h83, {16'h0000, rows[i].cc & 16'h8f3f}, 2'h0);
			chk("held_ratio", ratio, prev);
			pulse(1'b1, 1);
			prev = rows[i].ratio;
			chk("mode", mode, rows[i].sh[11]);
			chk("ratio", ratio, rows[i].ratio);
			chk("chop", chop, rows[i].sh[3]);
			chk("delay", dly, rows[i].dly);
			chk("gain", {x8, shift}, {rows[i].x8, rows[i].shift});
			chk("path", path, rows[i].path);
			chk("src_pin", sp, rows[i].cc[5]);
			chk("snk_pin", kp, rows[i].cc[4]);
			chk("mags", {src, snk}, {rows[i].src, rows[i].snk});
		end
		// Signed trim split across two registers
		bus(1'b1, 8'h84, 16'h8123);
		bus(1'b1, 8'h85, 16'h45ff);
		rchk(8'h85, 32'h0000_4500, 2'h0);
		pulse(1'b1, 1);
		chk("trim", trim, 24'h812345);
		// Unmapped index: zero data, decode error, write dropped
		bus(1'b1, 8'h00, 16'hffff);
		rchk(8'h00, 32'h0000_0000, 2'h3);
		// Capture, back-to-back counter wrap
		cdata <= 24'habcdef;
		pulse(1'b0, 5);
		chk("result", res, 24'habcdef);
		chk("counter", cnt, 2'h1);
		rchk(8'h90, 32'h01ab_cdef, 2'h0);
		// Disable clears result; counter kept while voltage side on
		bus(1'b1, 8'h83, 16'h0010);
		// The clear acts one edge after the enable bit falls
		repeat (2) @(negedge clk);
		chk("enable", en, 1'b0);
		chk("result", res, 24'h000000);
		chk("counter", cnt, 2'h1);
		@(posedge clk);
		ven <= 1'b0;
		repeat (2) @(negedge clk);
		chk("counter", cnt, 2'h0);
		@(posedge clk);
		ven <= 1'b1;
		bus(1'b1, 8'h83, 16'h8010);
		pulse(1'b0, 1);
		@(posedge clk);
		sby <= 1'b1;
		repeat (2) @(negedge clk);
		chk("result", res, 24'h000000);
		// Power-down wins over a same-cycle capture
		@(posedge clk);
		sby <= 1'b0;
		pdn <= 1'b1;
		pulse(1'b0, 1);
		chk("result", res, 24'h000000);
		// Mid-run reset: settings return to their reset values
		@(posedge clk);
		rst <= 1'b1;
		pdn <= 1'b0;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("ratio", ratio, 14'h0400);
		chk("enable", en, 1'b1);
		chk("counter", cnt, 2'h0);
		rchk(8'h82, 32'h0000_0400, 2'h0);
		test_done();
	end
endmodule : sacp_top_bench
